/* File: logic/audio_clock_generation.sv */
// Audio clock generation: PLL lock model, three PLL-fed clock generator
// units with fifteen frame/bit clock domains, an always-on generator with
// ten domains, a master clock output and an AHB-Lite register slave.
// Assumes a single 20 MHz clock, with AHB-Lite inputs synchronous to it.
//
// Function
// - Three generator units, each a base rate plus fractions, fifteen rates.
// - Every one of the fifteen domains drives a bit clock and frame clock.
// - Frame rate is PLL output times N over 512 times M.
// - Generators one and two have nine-bit N and M.
// - Generator three has sixteen-bit N and M.
// - Generator two adds a fixed two-thirds division of its input.
// - PLL makes the core clock from the master input, 270.336 MHz nominal.
// - A lock flag sets once the PLL has locked and settled.
// - Always-on generator bypasses the PLL, two units, ten domains.
// - Always-on bit clocks never exceed 3.072 MHz.
// - Master clock out is reference over four times selectable N.
// - Master clock out toggles only while the PLL is enabled.
// - Clock crossings are glitch-free with no software involvement.
`timescale 1ns/1ps
`include "clkgen_regs.svh"

module audio_clock_generation
	import clkgen_pkg::*;
#(
	parameter int LOCK_CYCLES = `LOCK_CYCLES
) (
	input wire logic CLK_SYS, // System clock, 20 MHz.
	input wire logic RST_N, // Asynchronous reset, active low.
	input wire logic HSEL, // AHB-Lite slave select.
	input wire logic [31:0] HADDR, // AHB-Lite address.
	input wire logic [1:0] HTRANS, // AHB-Lite transfer type.
	input wire logic HWRITE, // AHB-Lite write flag.
	input wire logic [2:0] HSIZE, // AHB-Lite transfer size.
	input wire logic [31:0] HWDATA, // AHB-Lite write data.
	input wire logic HREADY, // AHB-Lite bus ready.
	output word_t HRDATA, // AHB-Lite read data.
	output logic HREADYOUT, // AHB-Lite slave ready.
	output logic HRESP, // AHB-Lite response, always OKAY.
	output logic IRQ, // Interrupt level.
	output logic PLL_LOCK, // PLL lock flag.
	output logic [14:0] BCLK, // PLL-fed bit clocks.
	output logic [14:0] LRCLK, // PLL-fed frame clocks.
	output logic [9:0] AO_BCLK, // Always-on bit clocks.
	output logic [9:0] AO_LRCLK, // Always-on frame clocks.
	output logic MCLK_OUT // Master clock output.
);
	localparam int NGEN = 3;
	localparam int NAO = 2;
	localparam int FRAC = 5;
	localparam int NDOM = NGEN * FRAC;
	localparam int NAODOM = NAO * FRAC;
	localparam int NNM = NGEN + NAO;

	if (LOCK_CYCLES < 1) begin : bad_par
		$error("LOCK_CYCLES must be at least one");
	end

	// ======================================================================
	// Functions
	// Picks the bit clock of a domain from its phase counter.
	function automatic logic bclk_pick(input phase_t p, input ratio_t code,
		input int k);
		int idx;
		idx = (code > 3'h4) ? k : (4 - int'(code)) + k;
		return p[idx];
	endfunction : bclk_pick

	// Byte offset of the N/M register of unit i.
	function automatic logic [7:0] nm_off(input int i);
		return `OFF_NM0 + 8'(4 * i);
	endfunction : nm_off

	// Writable bits of the N/M register of unit i.
	function automatic word_t nm_mask(input int i);
		return (i == 2) ? 32'hFFFF_FFFF : 32'h01FF_01FF;
	endfunction : nm_mask

	// ======================================================================
	// Declarations
	logic [5:0] ctrl_q;
	logic [1:0] mask_q;
	logic [1:0] int_q;
	logic [1:0] int_d;
	logic [1:0] ev;
	word_t nm_q [NNM];
	logic [29:0] ratio_a_q;
	logic [14:0] ratio_b_q;
	logic [29:0] ao_ratio_q;
	logic [3:0] mclk_sel_q;
	logic [4:0] mclk_acc_q;
	logic [4:0] mclk_sum;
	logic lock_prev_q;
	logic locked;
	logic dwr_q;
	logic [7:0] daddr_q;
	logic acc_en;
	logic rd_clr;
	word_t rdata;
	logic [44:0] ratio;
	logic [NGEN-1:0] gen_run;
	logic [NAO-1:0] ao_run;
	phase_t ph [NGEN];
	phase_t ao_ph [NAO];

	// ======================================================================
	// Bus slave
	// A transfer is taken when selected, ready and NONSEQ or SEQ.
	assign acc_en = HSEL && HREADY && HTRANS[1];
	assign rd_clr = acc_en && !HWRITE && (HADDR[7:0] == `OFF_INT_STAT);

	// Address phase of a write is held for its data phase.
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			dwr_q <= 1'b0;
			daddr_q <= 8'h00;
		end else begin
			dwr_q <= acc_en && HWRITE && (HSIZE == `HSIZE_WORD);
			daddr_q <= HADDR[7:0];
		end
	end

	// The slave never stalls and never errors.
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			HREADYOUT <= 1'b0;
			HRESP <= 1'b0;
		end else begin
			HREADYOUT <= 1'b1;
			HRESP <= 1'b0;
		end
	end

	// Read decode; unmapped offsets read as zero.
	always_comb begin
		rdata = '0;
		if (HADDR[7:0] == `OFF_CTRL) begin
			rdata = 32'(ctrl_q);
		end else if (HADDR[7:0] == `OFF_LOCK_STAT) begin
			rdata = 32'(locked);
		end else if (HADDR[7:0] == `OFF_INT_STAT) begin
			rdata = 32'(int_q);
		end else if (HADDR[7:0] == `OFF_INT_MASK) begin
			rdata = 32'(mask_q);
		end else if (HADDR[7:0] == `OFF_RATIO_A) begin
			rdata = 32'(ratio_a_q);
		end else if (HADDR[7:0] == `OFF_RATIO_B) begin
			rdata = 32'(ratio_b_q);
		end else if (HADDR[7:0] == `OFF_AO_RATIO) begin
			rdata = 32'(ao_ratio_q);
		end else if (HADDR[7:0] == `OFF_MCLK_SEL) begin
			rdata = 32'(mclk_sel_q);
		end
		for (int i = 0; i < NNM; i++) begin
			if (HADDR[7:0] == nm_off(i)) begin
				rdata = nm_q[i];
			end
		end
	end

	// Read data are registered in the address phase for the data phase.
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			HRDATA <= '0;
		end else if (acc_en && !HWRITE) begin
			HRDATA <= rdata;
		end else begin
			HRDATA <= '0;
		end
	end

	// ======================================================================
	// Control registers
	// Written in the data phase with the word on HWDATA.
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			ctrl_q <= `CTRL_RST;
			mask_q <= 2'h0;
			ratio_a_q <= '0;
			ratio_b_q <= '0;
			ao_ratio_q <= '0;
			mclk_sel_q <= `MCLK_SEL_RST;
		end else if (dwr_q) begin
			if (daddr_q == `OFF_CTRL) begin
				ctrl_q <= HWDATA[5:0];
			end else if (daddr_q == `OFF_INT_MASK) begin
				mask_q <= HWDATA[1:0];
			end else if (daddr_q == `OFF_RATIO_A) begin
				ratio_a_q <= HWDATA[29:0];
			end else if (daddr_q == `OFF_RATIO_B) begin
				ratio_b_q <= HWDATA[14:0];
			end else if (daddr_q == `OFF_AO_RATIO) begin
				ao_ratio_q <= HWDATA[29:0];
			end else if (daddr_q == `OFF_MCLK_SEL) begin
				mclk_sel_q <= HWDATA[3:0];
			end
		end
	end

	// N/M registers; unused bits of the nine-bit units stay zero.
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			for (int i = 0; i < NNM; i++) begin
				nm_q[i] <= `NM_RST;
			end
		end else begin
			for (int i = 0; i < NNM; i++) begin
				if (dwr_q && daddr_q == nm_off(i)) begin
					nm_q[i] <= HWDATA & nm_mask(i);
				end
			end
		end
	end

	// ======================================================================
	// PLL lock and interrupts
	// The core clock is the reference times the feedback ratio; here the
	// timer models only how long the loop takes to settle.
	pll_lock_timer #(
		.LOCK_CYCLES(LOCK_CYCLES)
	) u_lock (
		.clk(CLK_SYS),
		.rst_n(RST_N),
		.en(ctrl_q[`CTRL_PLL_EN]),
		.locked_q(locked)
	);

	assign PLL_LOCK = locked;

	// Lock gained and lock lost; a new event outranks a read clear.
	assign ev[`INT_LOCK] = locked && !lock_prev_q;
	assign ev[`INT_UNLOCK] = !locked && lock_prev_q;
	assign int_d = (int_q & ~{2{rd_clr}}) | ev;

	// Sticky status and the masked interrupt level.
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			lock_prev_q <= 1'b0;
			int_q <= 2'h0;
			IRQ <= 1'b0;
		end else begin
			lock_prev_q <= locked;
			int_q <= int_d;
			IRQ <= |(int_d & mask_q);
		end
	end

	// ======================================================================
	// PLL-fed generator units
	// PLL-fed units stand still until lock is reported.
	always_comb begin
		for (int i = 0; i < NGEN; i++) begin
			gen_run[i] = ctrl_q[`CTRL_GEN_LSB + i] && locked;
		end
		for (int j = 0; j < NAO; j++) begin
			ao_run[j] = ctrl_q[`CTRL_GEN_LSB + NGEN + j];
		end
	end

	// Unit one: nine-bit N and M.
	clkgen_divider #(
		.NW(`NM_W_SHORT)
	) u_gen1 (
		.clk(CLK_SYS),
		.rst_n(RST_N),
		.run(gen_run[0]),
		.num(nm_q[0][8:0]),
		.den(nm_q[0][`NM_M_LSB+:9]),
		.phase_q(ph[0])
	);

	// Unit two: nine-bit N and M behind a fixed two-thirds divider.
	clkgen_divider #(
		.NW(`NM_W_SHORT),
		.INC_MUL(`INC_BASE * `G2_NUM),
		.DEN_MUL(`G2_DEN)
	) u_gen2 (
		.clk(CLK_SYS),
		.rst_n(RST_N),
		.run(gen_run[1]),
		.num(nm_q[1][8:0]),
		.den(nm_q[1][`NM_M_LSB+:9]),
		.phase_q(ph[1])
	);

	// Unit three: sixteen-bit N and M for arbitrary rates.
	clkgen_divider #(
		.NW(`NM_W_LONG)
	) u_gen3 (
		.clk(CLK_SYS),
		.rst_n(RST_N),
		.run(gen_run[2]),
		.num(nm_q[2][15:0]),
		.den(nm_q[2][`NM_M_LSB+:16]),
		.phase_q(ph[2])
	);

	// ======================================================================
	// Always-on generator units
	// They run from the reference directly and pace steps to cap the bit clock.
	for (genvar j = 0; j < NAO; j++) begin : g_ao
		clkgen_divider #(
			.NW(`NM_W_SHORT),
			.MIN_GAP(`AO_MIN_GAP)
		) u_ao (
			.clk(CLK_SYS),
			.rst_n(RST_N),
			.run(ao_run[j]),
			.num(nm_q[NGEN + j][8:0]),
			.den(nm_q[NGEN + j][`NM_M_LSB+:9]),
			.phase_q(ao_ph[j])
		);
	end

	// ======================================================================
	// Domain outputs
	// Domain d uses unit d/5 at the base rate divided by two to the d%5.
	assign ratio = {ratio_b_q, ratio_a_q};

	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			BCLK <= '0;
			LRCLK <= '0;
		end else begin
			for (int d = 0; d < NDOM; d++) begin
				BCLK[d] <= bclk_pick(ph[d / FRAC], ratio[d * 3 +: 3], d % FRAC);
				LRCLK[d] <= ph[d / FRAC][`PHASE_FRAME_BIT + d % FRAC];
			end
		end
	end

	// Always-on domains, laid out the same way over two units.
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			AO_BCLK <= '0;
			AO_LRCLK <= '0;
		end else begin
			for (int d = 0; d < NAODOM; d++) begin
				AO_BCLK[d] <= bclk_pick(ao_ph[d / FRAC], ao_ratio_q[d * 3 +: 3],
					d % FRAC);
				AO_LRCLK[d] <= ao_ph[d / FRAC][`PHASE_FRAME_BIT + d % FRAC];
			end
		end
	end

	// ======================================================================
	// Master clock output
	// Toggle steps come at reference times N over two, so the output is
	// reference over four times N, limited to half the reference.
	assign mclk_sum = mclk_acc_q + 5'(mclk_sel_q);

	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			mclk_acc_q <= '0;
			MCLK_OUT <= 1'b0;
		end else if (!ctrl_q[`CTRL_PLL_EN]) begin
			mclk_acc_q <= '0;
			MCLK_OUT <= 1'b0;
		end else if (mclk_sum >= 5'(`MCLK_WRAP)) begin
			MCLK_OUT <= !MCLK_OUT;
			if (mclk_sum - 5'(`MCLK_WRAP) >= 5'(`MCLK_WRAP)) begin
				mclk_acc_q <= '0;
			end else begin
				mclk_acc_q <= mclk_sum - 5'(`MCLK_WRAP);
			end
		end else begin
			mclk_acc_q <= mclk_sum;
		end
	end
endmodule : audio_clock_generation

/* File: logic/clkgen_divider.sv */
// One N/M clock generator unit: a fractional accumulator that advances a
// phase counter at 1024 steps per frame of the base rate.
// Assumes num and den are static or change only by register writes.
`timescale 1ns/1ps
`include "clkgen_regs.svh"

module clkgen_divider
	import clkgen_pkg::*;
#(
	parameter int NW = 9,
	parameter int INC_MUL = `INC_BASE,
	parameter int DEN_MUL = 1,
	parameter int MIN_GAP = 1,
	parameter int GW = 3
) (
	input wire logic clk, // System clock.
	input wire logic rst_n, // Asynchronous reset, active low.
	input wire logic run, // Unit running level.
	input wire logic [NW-1:0] num, // Numerator N.
	input wire logic [NW-1:0] den, // Denominator M.
	output phase_t phase_q // Phase counter.
);
	localparam int AW = NW + 4;

	if (NW < 1 || NW > 16 || MIN_GAP < 1 || MIN_GAP >= 2 ** GW) begin : bad_par
		$error("clkgen_divider parameters out of range");
	end

	logic [NW-1:0] n_q;
	logic [NW-1:0] m_q;
	logic [AW-1:0] acc_q;
	logic [GW-1:0] gap_q;
	logic [AW-1:0] inc;
	logic [AW-1:0] lim;
	logic [AW-1:0] sum;
	logic [AW-1:0] rem;

	// Step N*INC against M*DEN gives steps at f*N/(512*M) times 1024.
	assign inc = AW'(n_q) * AW'(INC_MUL);
	assign lim = AW'(m_q) * AW'(DEN_MUL);
	assign sum = acc_q + inc;
	assign rem = sum - lim;

	// ======================================================================
	// Accumulator and phase
	// New N and M are taken only while stopped or at a frame wrap, so edges never glitch.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			acc_q <= '0;
			phase_q <= '0;
			gap_q <= '0;
			n_q <= '0;
			m_q <= '0;
		end else if (!run) begin
			acc_q <= '0;
			phase_q <= '0;
			gap_q <= '0;
			n_q <= num;
			m_q <= den;
		end else if (gap_q != '0) begin
			gap_q <= gap_q - GW'(1);
		end else if (sum >= lim) begin
			acc_q <= (rem >= lim) ? '0 : rem;
			phase_q <= phase_q + `PHASE_W'(1);
			gap_q <= GW'(MIN_GAP - 1);
			if (&phase_q[`PHASE_FRAME_BIT:0]) begin
				n_q <= num;
				m_q <= den;
			end
		end else begin
			acc_q <= sum;
		end
	end
endmodule : clkgen_divider

/* File: logic/clkgen_pkg.sv */
// Types shared by the audio clock generation modules.
// Assumes the constants header is on the include path.
`include "clkgen_regs.svh"

package clkgen_pkg;
	typedef logic [31:0] word_t;
	typedef logic [`PHASE_W-1:0] phase_t;
	typedef logic [2:0] ratio_t;
endpackage : clkgen_pkg

/* File: logic/clkgen_regs.svh */
// Register offsets, field positions, reset values and timing counts of the
// audio clock generation block.
// Assumes a 20 MHz system clock and a word-aligned AHB-Lite register map.
`ifndef CLKGEN_REGS_SVH
`define CLKGEN_REGS_SVH

// ==========================================================================
// Clock figures
`define CLK_HZ 20000000
`define PLL_OUT_HZ 270336000
`define PLL_REF_HZ 12288000
`define LOCK_TIME_US 500
`define LOCK_CYCLES (`LOCK_TIME_US * (`CLK_HZ / 1000000))
`define AO_BCLK_MAX_HZ 3072000
`define AO_MIN_GAP ((`CLK_HZ + 2 * `AO_BCLK_MAX_HZ - 1) / (2 * `AO_BCLK_MAX_HZ))
`define FRAME_DIV 512
`define PHASE_W 14
`define PHASE_FRAME_BIT 9
`define INC_BASE ((1 << (`PHASE_FRAME_BIT + 1)) / `FRAME_DIV)
`define G2_NUM 2
`define G2_DEN 3
`define NM_W_SHORT 9
`define NM_W_LONG 16
`define MCLK_REF_DIV 4
`define MCLK_WRAP (`MCLK_REF_DIV / 2)
`define HSIZE_WORD 3'h2

// ==========================================================================
// Register offsets
`define OFF_CTRL 8'h00
`define OFF_LOCK_STAT 8'h04
`define OFF_INT_STAT 8'h08
`define OFF_INT_MASK 8'h0C
`define OFF_NM0 8'h10
`define OFF_RATIO_A 8'h24
`define OFF_RATIO_B 8'h28
`define OFF_AO_RATIO 8'h2C
`define OFF_MCLK_SEL 8'h30

// ==========================================================================
// Fields and reset values
`define CTRL_PLL_EN 0
`define CTRL_GEN_LSB 1
`define NM_M_LSB 16
`define INT_LOCK 0
`define INT_UNLOCK 1
`define CTRL_RST 6'h00
`define NM_RST 32'h0001_0001
`define MCLK_SEL_RST 4'h1

`endif

/* File: logic/pll_lock_timer.sv */
// Lock model of the integer PLL: raises the lock flag a fixed time after
// enable and drops it at once when the PLL is disabled.
// Assumes en is synchronous to clk.
`timescale 1ns/1ps
`include "clkgen_regs.svh"

module pll_lock_timer #(
	parameter int LOCK_CYCLES = `LOCK_CYCLES
) (
	input wire logic clk, // System clock.
	input wire logic rst_n, // Asynchronous reset, active low.
	input wire logic en, // PLL enable level.
	output logic locked_q // Lock flag.
);
	localparam int CW = $clog2(LOCK_CYCLES + 1);

	if (LOCK_CYCLES < 1) begin : bad_lock
		$error("LOCK_CYCLES must be at least one");
	end

	logic [CW-1:0] cnt_q;

	// ======================================================================
	// Lock counter
	// Counts enabled cycles; disabling clears both count and flag.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt_q <= '0;
			locked_q <= 1'b0;
		end else if (!en) begin
			cnt_q <= '0;
			locked_q <= 1'b0;
		end else if (cnt_q == CW'(LOCK_CYCLES - 1)) begin
			locked_q <= 1'b1;
		end else begin
			cnt_q <= cnt_q + CW'(1);
		end
	end
endmodule : pll_lock_timer

/* File: testbench/acg_properties.sv */
// Concurrent checks on the ports of the audio clock generation block.
// Assumes it is bound into the top module, all ports connected by name.
`timescale 1ns/1ps

module acg_properties
	import clkgen_pkg::*;
#(
	parameter int LOCK_CYCLES = 10000
) (
	input wire logic CLK_SYS, // System clock.
	input wire logic RST_N, // Reset, active low.
	input wire logic HSEL, // Slave select.
	input wire logic [31:0] HADDR, // Address.
	input wire logic [2:0] HSIZE, // Transfer size.
	input wire logic [31:0] HWDATA, // Write data.
	input wire logic [1:0] HTRANS, // Transfer type.
	input wire logic HWRITE, // Write flag.
	input wire logic HREADY, // Bus ready.
	input word_t HRDATA, // Read data.
	input wire logic HREADYOUT, // Slave ready.
	input wire logic HRESP, // Response.
	input wire logic PLL_LOCK, // Lock flag.
	input wire logic [14:0] BCLK, // Bit clocks.
	input wire logic [14:0] LRCLK, // Frame clocks.
	input wire logic [9:0] AO_BCLK, // Always-on bit clocks.
	input wire logic MCLK_OUT // Master clock output.
);
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RST_N);

	// ==========================================================
	// Helpers
	// A read taken at this edge, the loop enable mirrored from control writes,
	// and the cycles spent enabled without lock.
	logic rd_req;
	logic en_wr_q;
	logic en_q;
	logic [15:0] low_q;
	assign rd_req = HSEL && HREADY && HTRANS[1] && !HWRITE;
	always_ff @(posedge CLK_SYS or negedge RST_N) begin
		if (!RST_N) begin
			en_wr_q <= 1'b0;
			en_q <= 1'b0;
			low_q <= 16'h0000;
		end else begin
			en_wr_q <= HSEL && HREADY && HTRANS[1] && HWRITE && (HSIZE == 3'h2) &&
				(HADDR[7:0] == 8'h00);
			if (en_wr_q) begin
				en_q <= HWDATA[0];
			end
			if (!en_q || PLL_LOCK) begin
				low_q <= 16'h0000;
			end else if (low_q != 16'hFFFF) begin
				low_q <= low_q + 16'h0001;
			end
		end
	end
	sequence lock_up; $rose(PLL_LOCK); endsequence
	sequence lock_gone; (!PLL_LOCK)[*3]; endsequence
	sequence mclk_quiet; (!MCLK_OUT)[*4]; endsequence

	// ==========================================================
	// Assertions
	chk_ready_zero_wait: assert property ($past(RST_N) |-> HREADYOUT)
		else $error("slave ready low outside reset");
	chk_resp_okay: assert property (!HRESP)
		else $error("response not okay");
	chk_rdata_idle: assert property (!rd_req |=> HRDATA == 32'h0000_0000)
		else $error("read data outside a read data phase");
	chk_lock_delay: assert property (lock_up |-> low_q == LOCK_CYCLES)
		else $error("lock flag rose after the wrong settling time");
	chk_lock_cleared: assert property (!en_q |=> !PLL_LOCK)
		else $error("lock flag set with the loop disabled");
	chk_gen_gated: assert property (lock_gone |-> BCLK == 15'h0000 && LRCLK == 15'h0000)
		else $error("clock output active without lock");
	chk_mclk_off: assert property ($fell(PLL_LOCK) |-> ##[0:2] mclk_quiet)
		else $error("master clock still toggling with the loop off");
	chk_ao_rate: assert property ($changed(AO_BCLK[0]) |=> ($stable(AO_BCLK[0]))[*3])
		else $error("always-on bit clock too fast");
	chk_frame_hold: assert property ($changed(LRCLK[0]) |=>
		($stable(LRCLK[0]) || !PLL_LOCK)[*8])
		else $error("frame clock edge too soon");
endmodule : acg_properties

/* File: testbench/audio_clock_generation_tb.sv */
// Self-checking bench for the audio clock generation block.
// Assumes the package, the checker and the frame meter are compiled first.
`timescale 1ns/1ps

module audio_clock_generation_tb
	import clkgen_pkg::*;
;
	localparam int LC = 20;
	logic clk_sys, rst_n, hsel, hwrite, hreadyout, hresp, irq, pll_lock, mclk_out, ao;
	logic [31:0] haddr, hwdata;
	logic [1:0] htrans;
	logic [2:0] hsize;
	word_t hrdata;
	logic [14:0] bclk, lrclk;
	logic [9:0] ao_bclk, ao_lrclk;
	int bad_count, checks_done, dom, period, bits, frames;

	audio_clock_generation #(.LOCK_CYCLES(LC)) dut_u (.CLK_SYS(clk_sys), .RST_N(rst_n),
		.HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize),
		.HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout),
		.HRESP(hresp), .IRQ(irq), .PLL_LOCK(pll_lock), .BCLK(bclk), .LRCLK(lrclk),
		.AO_BCLK(ao_bclk), .AO_LRCLK(ao_lrclk), .MCLK_OUT(mclk_out));
	frame_meter meter_u (.clk(clk_sys), .rst_n(rst_n), .lr(ao ? ao_lrclk[0] : lrclk[dom]),
		.bc(ao ? ao_bclk[0] : bclk[dom]), .period(period), .bits(bits), .frames(frames));

	// ==========================================================
	// Support tasks
	// Ends the run with the counts and the verdict.
	task results();
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask : results

	// Compares one value and reports a difference.
	task chk(input word_t got, input word_t exp);
		checks_done++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// One single word transfer; the address phase is held until ready.
	task bus(input logic w, input logic [7:0] a, input word_t d, output word_t q);
		int n;
		@(posedge clk_sys);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h000000, a};
		hsize <= 3'h2;
		n = 0;
		do begin @(posedge clk_sys); n++; end while (hreadyout !== 1'b1 && n < 50);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do begin @(posedge clk_sys); n++; end while (hreadyout !== 1'b1 && n < 100);
		q = hrdata;
		if (n >= 100) begin
			bad_count++;
			$display("mismatch at %0t: got %h expected %h", $time, n, 32'h2);
		end
	endtask : bus

	// Register write, and register read with comparison.
	task wr(input logic [7:0] a, input word_t d);
		word_t q;
		bus(1'b1, a, d, q);
	endtask : wr
	task rd(input logic [7:0] a, input word_t e);
		word_t q;
		bus(1'b0, a, 32'h0000_0000, q);
		chk(q, e);
	endtask : rd

	// Measures one whole master clock period in cycles.
	task mper(input int e);
		int n, k;
		n = 0;
		k = 0;
		repeat (8) @(posedge clk_sys);
		while (mclk_out !== 1'b0 && k < 20) begin @(posedge clk_sys); k++; end
		while (mclk_out !== 1'b1 && k < 40) begin @(posedge clk_sys); k++; end
		while (mclk_out !== 1'b0 && k < 60) begin @(posedge clk_sys); k++; n++; end
		while (mclk_out !== 1'b1 && k < 80) begin @(posedge clk_sys); k++; n++; end
		chk(n, e);
	endtask : mper

	// Lets the meter settle on a domain, then checks frame length and bits.
	task frame(input logic a, input int d, input int p, input int b);
		int f0, n;
		ao = a;
		dom = d;
		f0 = frames;
		n = 0;
		while (frames < f0 + 3 && n < 20000) begin @(posedge clk_sys); n++; end
		chk(n < 20000, 32'h1);
		chk(period, p);
		chk(bits, b);
	endtask : frame

	// ==========================================================
	// Scenarios
	// Reset values, an unmapped place, a read-only place and field widths.
	task t_reset();
		rd(8'h00, 32'h0000_0000);
		rd(8'h0C, 32'h0000_0000);
		rd(8'h10, 32'h0001_0001);
		rd(8'h30, 32'h0000_0001);
		wr(8'h40, 32'hFFFF_FFFF);
		rd(8'h40, 32'h0000_0000);
		wr(8'h04, 32'h0000_0001);
		rd(8'h04, 32'h0000_0000);
		wr(8'h10, 32'hFFFF_FFFF);
		rd(8'h10, 32'h01FF_01FF);
		wr(8'h18, 32'hFFFF_FFFF);
		rd(8'h18, 32'hFFFF_FFFF);
		chk(pll_lock, 32'h0);
		chk(mclk_out, 32'h0);
	endtask : t_reset

	// Lock time, lock interrupt raised and cleared by reading the status.
	task t_lock();
		int n;
		wr(8'h0C, 32'h0000_0001);
		wr(8'h00, 32'h0000_0001);
		n = 0;
		while (pll_lock !== 1'b1 && n < 200) begin @(posedge clk_sys); n++; end
		chk(n >= LC && n <= LC + 2, 32'h1);
		repeat (2) @(posedge clk_sys);
		chk(irq, 32'h1);
		rd(8'h04, 32'h0000_0001);
		rd(8'h08, 32'h0000_0001);
		repeat (2) @(posedge clk_sys);
		chk(irq, 32'h0);
		rd(8'h08, 32'h0000_0000);
	endtask : t_lock

	// Master clock output at selectable factors one and two.
	task t_mclk();
		wr(8'h30, 32'h0000_0001);
		mper(4);
		wr(8'h30, 32'h0000_0002);
		mper(2);
	endtask : t_mclk

	// Bit clock codes zero to four, a fraction domain, the two-thirds unit and the wide unit.
	task t_domains();
		wr(8'h10, 32'h0002_0001);
		wr(8'h00, 32'h0000_0003);
		for (int c = 0; c < 5; c++) begin
			wr(8'h24, c);
			frame(1'b0, 0, 1024, 32 << c);
		end
		wr(8'h24, 32'h0000_0000);
		frame(1'b0, 1, 2048, 32);
		wr(8'h14, 32'h0002_0001);
		wr(8'h00, 32'h0000_0007);
		frame(1'b0, 5, 1536, 32);
		wr(8'h18, 32'h0400_0200);
		wr(8'h00, 32'h0000_000F);
		frame(1'b0, 10, 1024, 32);
		wr(8'h10, 32'h0004_0001);
		frame(1'b0, 0, 2048, 32);
	endtask : t_domains

	// Loop off: masked loss event, quiet outputs, always-on unit still running.
	task t_off();
		wr(8'h1C, 32'h0002_0001);
		wr(8'h2C, 32'h0000_0004);
		wr(8'h00, 32'h0000_0010);
		repeat (6) @(posedge clk_sys);
		chk(pll_lock, 32'h0);
		chk(mclk_out, 32'h0);
		chk(bclk, 32'h0);
		chk(irq, 32'h0);
		rd(8'h08, 32'h0000_0002);
		frame(1'b1, 0, 4096, 512);
	endtask : t_off

	// ==========================================================
	// Processes
	// Free-running system clock, never stopped or retuned.
	initial begin
		clk_sys = 1'b0;
		forever #25 clk_sys = ~clk_sys;
	end

	// Reset, then the scenarios in order.
	initial begin
		{rst_n, hsel, hwrite, ao, haddr, hwdata, htrans, hsize} = '0;
		{bad_count, checks_done, dom} = '0;
		repeat (5) @(posedge clk_sys);
		rst_n <= 1'b1;
		t_reset();
		t_lock();
		t_mclk();
		t_domains();
		t_off();
		results();
	end

	// Watchdog against a hang.
	initial begin
		repeat (100000) @(posedge clk_sys);
		bad_count++;
		results();
	end
endmodule : audio_clock_generation_tb

bind audio_clock_generation acg_properties #(.LOCK_CYCLES(LOCK_CYCLES)) chk_u (
	.CLK_SYS(CLK_SYS), .RST_N(RST_N), .HSEL(HSEL), .HADDR(HADDR), .HSIZE(HSIZE),
	.HWDATA(HWDATA), .HTRANS(HTRANS), .HWRITE(HWRITE),
	.HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
	.PLL_LOCK(PLL_LOCK), .BCLK(BCLK), .LRCLK(LRCLK), .AO_BCLK(AO_BCLK), .MCLK_OUT(MCLK_OUT));

/* File: testbench/frame_meter.sv */
// Downstream serial device model: measures frame length and bit clocks per frame.
// Assumes frame and bit clocks are levels sampled on the system clock.
`timescale 1ns/1ps

module frame_meter (
	input wire logic clk, // Sampling clock.
	input wire logic rst_n, // Reset, active low.
	input wire logic lr, // Frame clock.
	input wire logic bc, // Bit clock.
	output int period, // Cycles of the last whole frame.
	output int bits, // Bit clock rises in that frame.
	output int frames // Frames seen.
);
	logic lr_q, bc_q;
	int cnt, bcnt;

	// A frame starts on each frame clock rise; bit clock rises are counted inside.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			lr_q <= 1'b0;
			bc_q <= 1'b0;
			{cnt, bcnt, period, bits, frames} <= '0;
		end else begin
			lr_q <= lr;
			bc_q <= bc;
			cnt <= cnt + 1;
			bcnt <= bcnt + int'(bc && !bc_q);
			if (lr && !lr_q) begin
				period <= cnt + 1;
				bits <= bcnt;
				bcnt <= int'(bc && !bc_q);
				cnt <= 0;
				frames <= frames + 1;
			end
		end
	end
endmodule : frame_meter
